/* common/switchgear_pkg.sv */
// constants, types and timing for the switchgear object control block
package switchgear_pkg;
   localparam int unsigned CLK_HZ = 100000000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   // times in milliseconds
   localparam int unsigned TRAVERSE_MS = 200;
   localparam int unsigned PULSE_MS = 200;
   localparam int unsigned TERM_TIMEOUT_MS = 10000;
   localparam logic [31:0] TRAVERSE_CYC = 32'(TRAVERSE_MS * CYC_PER_MS);
   localparam logic [31:0] PULSE_CYC = 32'(PULSE_MS * CYC_PER_MS);
   localparam logic [31:0] TERM_TIMEOUT_CYC =
      32'(TERM_TIMEOUT_MS * CYC_PER_MS);
   // output and counter geometry
   localparam int unsigned NUM_OUT = 8;
   localparam int unsigned OUT_SEL_W = 3;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned NUM_IND = 4;
   // event codes and mask positions
   localparam int unsigned NUM_EVT = 6;
   localparam int unsigned EVT_W = 3;
   localparam logic [2:0] EV_STATUS = 3'h0;
   localparam logic [2:0] EV_OPEN_REQ = 3'h1;
   localparam logic [2:0] EV_CLOSE_REQ = 3'h2;
   localparam logic [2:0] EV_OPEN_FAIL = 3'h3;
   localparam logic [2:0] EV_CLOSE_FAIL = 3'h4;
   localparam logic [2:0] EV_CLOSE_BLOCKED = 3'h5;
   localparam logic [5:0] EVT_MASK_RESET = 6'h00;
   // indication bit positions
   localparam int unsigned IND_OPEN = 0;
   localparam int unsigned IND_CLOSED = 1;
   localparam int unsigned IND_INTER = 2;
   localparam int unsigned IND_BAD = 3;
   // reset values of configuration
   localparam logic ENABLE_RESET = 1'b0;
   localparam logic REMOTE_RESET = 1'b0;
   // status coded as {close, open} feedback
   typedef enum logic [1:0] {
      ST_INTER = 2'b00,
      ST_OPEN = 2'b01,
      ST_CLOSED = 2'b10,
      ST_BAD = 2'b11
   } pos_status_e;
   typedef enum logic [1:0] {
      TY_GROUND_DISC = 2'b00,
      TY_MOTOR_DISC = 2'b01,
      TY_BREAKER = 2'b10,
      TY_WITHDRAWABLE = 2'b11
   } obj_type_e;
   typedef enum logic [1:0] {
      CS_IDLE = 2'b00,
      CS_OPENING = 2'b01,
      CS_CLOSING = 2'b10
   } ctl_state_e;
endpackage

/* common/pos_if.sv */
// feedback pair and decoded status between owner and decoder
`timescale 1ns/10ps
interface pos_if;
   logic fb_open;
   logic fb_close;
   switchgear_pkg::pos_status_e status;
   modport decoder(input fb_open, input fb_close, output status);
   modport owner(output fb_open, output fb_close, input status);
endinterface

/* verilog/position_decoder.sv */
// decodes a feedback pair into a four-state position with traverse delay
`timescale 1ns/10ps
module position_decoder #(
   parameter logic [31:0] TRAVERSE_CYC = switchgear_pkg::TRAVERSE_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // feedback pair and status
   pos_if.decoder pos
);
   logic [31:0] trav_cnt;
   logic [31:0] next_trav_cnt;
   switchgear_pkg::pos_status_e next_status;

   always_comb begin
      next_trav_cnt = 32'h0;
      next_status = pos.status;
      case ({pos.fb_close, pos.fb_open})
         2'b01: next_status = switchgear_pkg::ST_OPEN;
         2'b10: next_status = switchgear_pkg::ST_CLOSED;
         2'b11: next_status = switchgear_pkg::ST_BAD;
         default: begin
            // travel: keep last decoded status (open, closed or bad) until traverse time runs out
            if (trav_cnt >= TRAVERSE_CYC - 32'h1) begin
               next_status = switchgear_pkg::ST_INTER;
               next_trav_cnt = trav_cnt;
            end else begin
               next_trav_cnt = trav_cnt + 32'h1;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         trav_cnt <= 32'h0;
         pos.status <= switchgear_pkg::ST_INTER;
      end else begin
         trav_cnt <= next_trav_cnt;
         pos.status <= next_status;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   AST_BAD_BOTH_HIGH: assert property (
      pos.fb_open && pos.fb_close |=> pos.status == switchgear_pkg::ST_BAD)
      else $error("both feedback high did not give bad");
   AST_SINGLE_END: assert property (
      pos.fb_open && !pos.fb_close ##1 pos.fb_open && !pos.fb_close
      |-> pos.status == switchgear_pkg::ST_OPEN)
      else $error("open feedback did not give open");
   AST_TRAVERSE_HOLD: assert property (
      !pos.fb_open && !pos.fb_close && trav_cnt < TRAVERSE_CYC - 32'h1
      |=> pos.status == $past(pos.status))
      else $error("intermediate reported before traverse time");
   AST_INTER_AFTER: assert property (
      !pos.fb_open && !pos.fb_close && trav_cnt >= TRAVERSE_CYC - 32'h1
      |=> pos.status == switchgear_pkg::ST_INTER)
      else $error("intermediate missing after traverse time");
endmodule

/* verilog/switchgear_object_control.sv */
// one controllable switchgear object: access, permits, pulses, statistics
`timescale 1ns/10ps
module switchgear_object_control #(
   parameter logic [31:0] TRAVERSE_CYC = switchgear_pkg::TRAVERSE_CYC,
   parameter logic [31:0] PULSE_CYC = switchgear_pkg::PULSE_CYC,
   parameter logic [31:0] TIMEOUT_CYC = switchgear_pkg::TERM_TIMEOUT_CYC,
   parameter int unsigned NUM_OUT = switchgear_pkg::NUM_OUT,
   parameter int unsigned OUT_SEL_W = switchgear_pkg::OUT_SEL_W,
   parameter int unsigned CNT_W = switchgear_pkg::CNT_W
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // configuration
   input wire logic cfg_enable,
   input wire logic cfg_remote,
   input wire logic [1:0] cfg_type,
   input wire logic cfg_use_ready,
   input wire logic cfg_use_sync,
   input wire logic [OUT_SEL_W-1:0] cfg_open_out,
   input wire logic [OUT_SEL_W-1:0] cfg_close_out,
   input wire logic [switchgear_pkg::NUM_IND-1:0] cfg_ind_latched,
   input wire logic [switchgear_pkg::NUM_EVT-1:0] cfg_evt_mask,
   input wire logic cfg_cart_in_logic_src,
   input wire logic cfg_cart_out_logic_src,
   // software strobes
   input wire logic clear_stats,
   input wire logic ind_ack,
   // position and permit inputs
   input wire logic fb_open,
   input wire logic fb_close,
   input wire logic cart_in_line,
   input wire logic cart_in_logic,
   input wire logic cart_out_line,
   input wire logic cart_out_logic,
   input wire logic ready_in,
   input wire logic sync_in,
   // request inputs
   input wire logic local_open_req,
   input wire logic local_close_req,
   input wire logic remote_open_req,
   input wire logic remote_close_req,
   input wire logic app_open_req,
   input wire logic app_close_req,
   // physical outputs and indications
   output logic [NUM_OUT-1:0] cmd_out,
   output logic [switchgear_pkg::NUM_IND-1:0] ind_out,
   // status and statistics
   output logic [1:0] obj_status,
   output logic [1:0] cart_status,
   output logic [CNT_W-1:0] open_requests,
   output logic [CNT_W-1:0] close_requests,
   output logic [CNT_W-1:0] open_failed,
   output logic [CNT_W-1:0] close_failed,
   // event history feed
   output logic evt_valid,
   output logic [switchgear_pkg::EVT_W-1:0] evt_code
);
   pos_if brk ();
   pos_if cart ();

   // configuration held with defined reset values
   logic enable_q;
   logic remote_q;
   switchgear_pkg::obj_type_e type_q;
   logic [switchgear_pkg::NUM_EVT-1:0] mask_q;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         enable_q <= switchgear_pkg::ENABLE_RESET;
         remote_q <= switchgear_pkg::REMOTE_RESET;
         type_q <= switchgear_pkg::TY_BREAKER;
         mask_q <= switchgear_pkg::EVT_MASK_RESET;
      end else begin
         enable_q <= cfg_enable;
         remote_q <= cfg_remote;
         type_q <= switchgear_pkg::obj_type_e'(cfg_type);
         mask_q <= cfg_evt_mask;
      end
   end

   // feedback decoding
   logic is_wd;
   assign is_wd = (type_q == switchgear_pkg::TY_WITHDRAWABLE);
   assign brk.fb_open = fb_open;
   assign brk.fb_close = fb_close;
   // cart feedback only exists on a withdrawable object
   assign cart.fb_close = is_wd && (cfg_cart_in_logic_src ?
      cart_in_logic : cart_in_line);
   assign cart.fb_open = is_wd && (cfg_cart_out_logic_src ?
      cart_out_logic : cart_out_line);

   position_decoder #(.TRAVERSE_CYC(TRAVERSE_CYC)) u_brk_dec (
      .mclk(mclk),
      .reset_n(reset_n),
      .pos(brk.decoder)
   );
   position_decoder #(.TRAVERSE_CYC(TRAVERSE_CYC)) u_cart_dec (
      .mclk(mclk),
      .reset_n(reset_n),
      .pos(cart.decoder)
   );
   assign obj_status = brk.status;
   assign cart_status = cart.status;

   // request qualification
   logic want_open;
   logic want_close;
   logic permit_ok;
   logic open_accept;
   logic close_accept;
   logic close_blocked;

   switchgear_pkg::ctl_state_e state;
   switchgear_pkg::ctl_state_e next_state;
   logic [31:0] tmr;
   logic [31:0] next_tmr;
   logic open_fail;
   logic close_fail;

   // application inputs bypass the access selector
   assign want_open = app_open_req || (remote_q ? remote_open_req :
      local_open_req);
   assign want_close = app_close_req || (remote_q ? remote_close_req :
      local_close_req);
   assign permit_ok = (!cfg_use_ready || ready_in) &&
      (!cfg_use_sync || sync_in);
   // open wins a tie: opening is the safe direction
   assign open_accept = enable_q && state == switchgear_pkg::CS_IDLE &&
      want_open;
   assign close_accept = enable_q && state == switchgear_pkg::CS_IDLE &&
      !want_open && want_close && permit_ok;
   assign close_blocked = enable_q && state == switchgear_pkg::CS_IDLE &&
      !want_open && want_close && !permit_ok;

   always_comb begin
      next_state = state;
      next_tmr = tmr;
      open_fail = 1'b0;
      close_fail = 1'b0;
      case (state)
         switchgear_pkg::CS_IDLE: begin
            next_tmr = 32'h0;
            if (open_accept) begin
               next_state = switchgear_pkg::CS_OPENING;
            end else if (close_accept) begin
               next_state = switchgear_pkg::CS_CLOSING;
            end
         end
         switchgear_pkg::CS_OPENING: begin
            next_tmr = tmr + 32'h1;
            if (brk.status == switchgear_pkg::ST_OPEN) begin
               next_state = switchgear_pkg::CS_IDLE;
            end else if (tmr >= TIMEOUT_CYC - 32'h1) begin
               next_state = switchgear_pkg::CS_IDLE;
               open_fail = 1'b1;
            end
         end
         switchgear_pkg::CS_CLOSING: begin
            next_tmr = tmr + 32'h1;
            if (brk.status == switchgear_pkg::ST_CLOSED) begin
               next_state = switchgear_pkg::CS_IDLE;
            end else if (tmr >= TIMEOUT_CYC - 32'h1) begin
               next_state = switchgear_pkg::CS_IDLE;
               close_fail = 1'b1;
            end
         end
         default: begin
            next_state = switchgear_pkg::CS_IDLE;
         end
      endcase
      // disabling aborts any request in flight
      if (!enable_q) begin
         next_state = switchgear_pkg::CS_IDLE;
         open_fail = 1'b0;
         close_fail = 1'b0;
      end
   end

   // command pulses; one state means one command at most
   logic open_pulse;
   logic close_pulse;
   logic next_open_pulse;
   logic next_close_pulse;
   logic [NUM_OUT-1:0] next_cmd;

   always_comb begin
      next_open_pulse = next_state == switchgear_pkg::CS_OPENING &&
         next_tmr < PULSE_CYC;
      next_close_pulse = next_state == switchgear_pkg::CS_CLOSING &&
         next_tmr < PULSE_CYC;
      next_cmd = '0;
      if (next_open_pulse) begin
         next_cmd[cfg_open_out] = 1'b1;
      end
      if (next_close_pulse) begin
         next_cmd[cfg_close_out] = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state <= switchgear_pkg::CS_IDLE;
         tmr <= 32'h0;
         open_pulse <= 1'b0;
         close_pulse <= 1'b0;
         cmd_out <= '0;
      end else begin
         state <= next_state;
         tmr <= next_tmr;
         open_pulse <= next_open_pulse;
         close_pulse <= next_close_pulse;
         cmd_out <= next_cmd;
      end
   end

   // statistics: a count arriving with the clear is kept as one
   function automatic logic [CNT_W-1:0] count_next(
      input logic [CNT_W-1:0] cur, input logic inc, input logic clr);
      logic [CNT_W-1:0] base;
      base = clr ? '0 : cur;
      return inc ? base + CNT_W'(1) : base;
   endfunction

   logic [CNT_W-1:0] next_open_requests;
   logic [CNT_W-1:0] next_close_requests;
   logic [CNT_W-1:0] next_open_failed;
   logic [CNT_W-1:0] next_close_failed;

   always_comb begin
      next_open_requests = count_next(open_requests, open_accept,
         clear_stats);
      next_close_requests = count_next(close_requests, close_accept,
         clear_stats);
      next_open_failed = count_next(open_failed, open_fail,
         clear_stats);
      next_close_failed = count_next(close_failed, close_fail,
         clear_stats);
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         open_requests <= '0;
         close_requests <= '0;
         open_failed <= '0;
         close_failed <= '0;
      end else begin
         open_requests <= next_open_requests;
         close_requests <= next_close_requests;
         open_failed <= next_open_failed;
         close_failed <= next_close_failed;
      end
   end

   // indications: latched ones hold until acknowledged, source wins ack
   logic [switchgear_pkg::NUM_IND-1:0] ind_src;
   logic [switchgear_pkg::NUM_IND-1:0] next_ind;

   always_comb begin
      ind_src = '0;
      ind_src[switchgear_pkg::IND_OPEN] =
         brk.status == switchgear_pkg::ST_OPEN;
      ind_src[switchgear_pkg::IND_CLOSED] =
         brk.status == switchgear_pkg::ST_CLOSED;
      ind_src[switchgear_pkg::IND_INTER] =
         brk.status == switchgear_pkg::ST_INTER;
      ind_src[switchgear_pkg::IND_BAD] =
         brk.status == switchgear_pkg::ST_BAD;
      next_ind = ind_src | (ind_out & cfg_ind_latched &
         {switchgear_pkg::NUM_IND{!ind_ack}});
   end

   // events: one per cycle, failures first; ones whose mask bit is clear are dropped
   switchgear_pkg::pos_status_e prev_status;
   logic next_evt_valid;
   logic [switchgear_pkg::EVT_W-1:0] next_evt_code;
   logic [switchgear_pkg::EVT_W-1:0] raw_code;
   logic raw_valid;

   always_comb begin
      raw_valid = 1'b1;
      if (open_fail) begin
         raw_code = switchgear_pkg::EV_OPEN_FAIL;
      end else if (close_fail) begin
         raw_code = switchgear_pkg::EV_CLOSE_FAIL;
      end else if (open_accept) begin
         raw_code = switchgear_pkg::EV_OPEN_REQ;
      end else if (close_accept) begin
         raw_code = switchgear_pkg::EV_CLOSE_REQ;
      end else if (close_blocked) begin
         raw_code = switchgear_pkg::EV_CLOSE_BLOCKED;
      end else begin
         raw_code = switchgear_pkg::EV_STATUS;
         raw_valid = brk.status != prev_status;
      end
      next_evt_valid = raw_valid && mask_q[raw_code];
      next_evt_code = raw_code;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ind_out <= '0;
         prev_status <= switchgear_pkg::ST_INTER;
         evt_valid <= 1'b0;
         evt_code <= switchgear_pkg::EV_STATUS;
      end else begin
         ind_out <= next_ind;
         prev_status <= brk.status;
         evt_valid <= next_evt_valid;
         evt_code <= next_evt_code;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   AST_DISABLED_QUIET: assert property (
      !enable_q |=> state == switchgear_pkg::CS_IDLE && cmd_out == '0)
      else $error("disabled object still commands");
   AST_ACCESS_REJECT: assert property (
      state == switchgear_pkg::CS_IDLE && !remote_q && !app_open_req &&
      !app_close_req && !local_open_req && !local_close_req
      |=> state == switchgear_pkg::CS_IDLE)
      else $error("rejected access source moved the object");
   AST_PERMIT_CLOSE: assert property (
      $rose(close_pulse) |-> $past(permit_ok))
      else $error("close issued without permits");
   AST_NO_BOTH: assert property (
      !(open_pulse && close_pulse))
      else $error("open and close driven together");
   AST_OPEN_COUNT: assert property (
      open_accept && !clear_stats
      |=> open_requests == $past(open_requests) + CNT_W'(1))
      else $error("open request not counted");
   AST_CLEAR_ZERO: assert property (
      clear_stats && !open_accept && !close_accept && !open_fail &&
      !close_fail |=> open_requests == '0 && close_requests == '0 &&
      open_failed == '0 && close_failed == '0)
      else $error("clear statistics left a count");
   AST_PULSE_CUT: assert property (
      state == switchgear_pkg::CS_OPENING &&
      brk.status == switchgear_pkg::ST_OPEN
      |=> !open_pulse && !cmd_out[cfg_open_out])
      else $error("open pulse not cut at position");
   AST_FAIL_TIMEOUT: assert property (
      enable_q && state == switchgear_pkg::CS_CLOSING &&
      tmr >= TIMEOUT_CYC - 32'h1 && brk.status != switchgear_pkg::ST_CLOSED
      && !clear_stats |=> close_failed == $past(close_failed) + CNT_W'(1)
      && state == switchgear_pkg::CS_IDLE)
      else $error("close timeout not counted as failure");
   AST_MASK_GATE: assert property (
      evt_valid |-> (($past(mask_q) >> evt_code) & 6'h01) != 6'h00)
      else $error("masked-off event logged");
   AST_APP_OPEN: assert property (
      enable_q && state == switchgear_pkg::CS_IDLE && app_open_req
      |=> state == switchgear_pkg::CS_OPENING && open_pulse)
      else $error("application open ignored");
endmodule

/* dv/breaker_model.sv */
// behavioural breaker: auxiliary contacts that follow the command coils
`timescale 1ns/10ps
module breaker_model (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // coil drive and output selection
   input wire logic [7:0] cmd_out,
   input wire logic [2:0] open_sel,
   input wire logic [2:0] close_sel,
   // fault steering: 0 normal, 1 both high, 2 both low
   input wire logic respond,
   input wire logic [1:0] fault,
   // auxiliary contacts
   output logic fb_open,
   output logic fb_close
);
   logic closed;
   logic tgt;
   int cnt;
   // travel of three cycles with both contacts released
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         closed <= 1'b0;
         tgt <= 1'b0;
         cnt <= 0;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
         if (cnt == 1)
            closed <= tgt;
      end else if (respond && cmd_out[open_sel] && closed) begin
         tgt <= 1'b0;
         cnt <= 3;
      end else if (respond && cmd_out[close_sel] && !closed) begin
         tgt <= 1'b1;
         cnt <= 3;
      end
   end
   assign fb_open = (fault == 2'h1) | (fault == 2'h0 && cnt == 0 && !closed);
   assign fb_close = (fault == 2'h1) | (fault == 2'h0 && cnt == 0 && closed);
endmodule

/* dv/switchgear_object_control_bench.sv */
// self-checking bench for the switchgear object control block
`timescale 1ns/10ps
module switchgear_object_control_bench;
   localparam logic [31:0] TRAV = 32'h8;
   localparam logic [31:0] PULSE = 32'h4;
   localparam logic [31:0] TMO = 32'h14;
   logic mclk, reset_n, cfg_enable, cfg_remote, cfg_use_ready, cfg_use_sync;
   logic cfg_cart_in_logic_src, cfg_cart_out_logic_src, clear_stats, ind_ack;
   logic fb_open, fb_close, cart_in_line, cart_in_logic, cart_out_line;
   logic cart_out_logic, ready_in, sync_in, respond, evt_valid, evt_seen;
   logic [1:0] cfg_type, fault, obj_status, cart_status;
   logic [2:0] cfg_open_out, cfg_close_out, evt_code, evt_last;
   logic [3:0] cfg_ind_latched, ind_out;
   logic [5:0] cfg_evt_mask;
   // requests: local open/close, remote open/close, app open/close
   logic [5:0] req;
   logic [7:0] cmd_out;
   logic [15:0] open_requests, close_requests, open_failed, close_failed;
   int err_count, cmp_count, n;
   switchgear_object_control #(.TRAVERSE_CYC(TRAV), .PULSE_CYC(PULSE),
      .TIMEOUT_CYC(TMO)) i_switchgear_object_control (.mclk(mclk),
      .reset_n(reset_n), .cfg_enable(cfg_enable), .cfg_remote(cfg_remote),
      .cfg_type(cfg_type), .cfg_use_ready(cfg_use_ready),
      .cfg_use_sync(cfg_use_sync), .cfg_open_out(cfg_open_out),
      .cfg_close_out(cfg_close_out), .cfg_ind_latched(cfg_ind_latched),
      .cfg_evt_mask(cfg_evt_mask),
      .cfg_cart_in_logic_src(cfg_cart_in_logic_src),
      .cfg_cart_out_logic_src(cfg_cart_out_logic_src),
      .clear_stats(clear_stats), .ind_ack(ind_ack), .fb_open(fb_open),
      .fb_close(fb_close), .cart_in_line(cart_in_line),
      .cart_in_logic(cart_in_logic), .cart_out_line(cart_out_line),
      .cart_out_logic(cart_out_logic), .ready_in(ready_in), .sync_in(sync_in),
      .local_open_req(req[0]), .local_close_req(req[1]),
      .remote_open_req(req[2]), .remote_close_req(req[3]),
      .app_open_req(req[4]), .app_close_req(req[5]), .cmd_out(cmd_out),
      .ind_out(ind_out), .obj_status(obj_status), .cart_status(cart_status),
      .open_requests(open_requests), .close_requests(close_requests),
      .open_failed(open_failed), .close_failed(close_failed),
      .evt_valid(evt_valid), .evt_code(evt_code));
   breaker_model i_breaker_model (.mclk(mclk), .reset_n(reset_n),
      .cmd_out(cmd_out), .open_sel(cfg_open_out), .close_sel(cfg_close_out),
      .respond(respond), .fault(fault), .fb_open(fb_open),
      .fb_close(fb_close));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic conclude();
      if (err_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   // one-cycle request pulse, sampled at the next edge
   task automatic issue(input int i);
      req[i] = 1'b1;
      tick(1);
      req = 6'h00;
   endtask
   task automatic wait_cmd(input logic [2:0] idx);
      n = 0;
      while (cmd_out[idx] !== 1'b1 && n < 10) begin
         tick(1);
         n++;
      end
      if (n == 10) begin
         err_count++;
         $display("ERROR %0t command pulse missing", $time);
         conclude();
      end
   endtask
   // event capture and a watch on overlapping commands
   always @(posedge mclk) begin
      if (evt_valid === 1'b1) begin
         evt_seen = 1'b1;
         evt_last = evt_code;
      end
      if ($countones(cmd_out) > 1) begin
         err_count++;
         $display("ERROR %0t open and close driven together", $time);
      end
   end
   initial begin
      {cfg_enable, cfg_remote, cfg_use_ready, cfg_use_sync, ind_ack} = 5'h00;
      {cfg_cart_in_logic_src, cfg_cart_out_logic_src, clear_stats} = 3'h0;
      {cart_in_line, cart_in_logic, cart_out_line, cart_out_logic} = 4'h0;
      {ready_in, sync_in, evt_seen} = 3'h0;
      {cfg_ind_latched, cfg_evt_mask, req, fault, evt_last} = 21'h00;
      cfg_type = 2'h2;
      cfg_open_out = 3'h1;
      cfg_close_out = 3'h6;
      respond = 1'b1;
      reset_n = 1'b0;
      tick(6);
      reset_n = 1'b1;
      tick(3);
      chk(obj_status, 2'h1);
      issue(4);
      tick(4);
      chk(cmd_out, 8'h00);
      chk(open_requests, 16'h0);
      cfg_enable = 1'b1;
      tick(1);
      issue(3);
      tick(4);
      chk(close_requests, 16'h0);
      issue(1);
      wait_cmd(3'h6);
      chk(close_requests, 16'h1);
      tick(8);
      chk(obj_status, 2'h2);
      chk(cmd_out, 8'h00);
      chk(evt_seen, 1'b0);
      cfg_remote = 1'b1;
      cfg_evt_mask = 6'h3f;
      tick(1);
      issue(0);
      tick(4);
      chk(open_requests, 16'h0);
      issue(2);
      wait_cmd(3'h1);
      tick(8);
      chk(open_requests, 16'h1);
      chk(obj_status, 2'h1);
      cfg_use_ready = 1'b1;
      issue(5);
      tick(4);
      chk(close_requests, 16'h1);
      chk(evt_last, 3'h5);
      cfg_use_sync = 1'b1;
      ready_in = 1'b1;
      issue(5);
      tick(4);
      chk(close_requests, 16'h1);
      sync_in = 1'b1;
      issue(5);
      wait_cmd(3'h6);
      tick(8);
      chk(close_requests, 16'h2);
      // no answer from the contacts: pulse runs full, then failure
      respond = 1'b0;
      cfg_remote = 1'b0;
      issue(4);
      wait_cmd(3'h1);
      n = 0;
      while (cmd_out[1] === 1'b1 && n < 50) begin
         tick(1);
         n++;
      end
      chk(16'(n), PULSE[15:0]);
      tick(30);
      chk(open_failed, 16'h1);
      chk(evt_last, 3'h3);
      clear_stats = 1'b1;
      tick(1);
      clear_stats = 1'b0;
      tick(1);
      chk(open_requests | close_requests, 16'h0);
      chk(open_failed | close_failed, 16'h0);
      cfg_ind_latched = 4'h8;
      fault = 2'h1;
      tick(3);
      chk(obj_status, 2'h3);
      fault = 2'h2;
      tick(3);
      chk(obj_status, 2'h3);
      tick(TRAV + 2);
      chk(obj_status, 2'h0);
      chk(ind_out, 4'hc);
      ind_ack = 1'b1;
      tick(1);
      ind_ack = 1'b0;
      tick(1);
      chk(ind_out, 4'h4);
      // close from intermediate with no contact answer: close failure
      issue(5);
      tick(TMO + 2);
      chk(close_requests, 16'h1);
      chk(close_failed, 16'h1);
      chk(evt_last, 3'h4);
      cart_in_line = 1'b1;
      tick(3);
      chk(cart_status, 2'h0);
      cfg_type = 2'h3;
      tick(3);
      chk(cart_status, 2'h2);
      {cfg_cart_in_logic_src, cfg_cart_out_logic_src, cart_out_logic} = 3'h7;
      tick(3);
      chk(cart_status, 2'h1);
      conclude();
   end
   // hang guard
   initial begin
      repeat (5000) @(posedge mclk);
      err_count++;
      $display("ERROR %0t run did not finish", $time);
      conclude();
   end
endmodule
